//--- hdl/fpms_top.sv
// fault protection and operating mode sequencer for one rail, apb slave
// assumes comparator levels arrive asynchronous and the host keeps apb rules
//
// Contract
// - rail off if feedback still low at the end of the start window
// - in regulation, feedback low continuously for the long window trips the rail
// - a trip sets short flag and summary, clears rail-on, pulls irq low
// - short flag clears only by host writing one to it (here the defaults load after off also clears it)
// - after short flag clears, start again while enable is still requested
// - filtered thermal shutdown: rail off, flag set, irq low, go standby
// - write one clears thermal flag and irq, not while condition lasts
// - live thermal shutdown status readable apart from the flag
// - no rail enable while thermal condition or thermal flag present
// - supply lockout: rail off at once, discharge on, enter off
// - supply good and reset pin high: sequence up to standby
// - after off, registers default and reset flag set, irq if unmasked
// - filters count clock samples, window exact to one clock
// - enable pins only synchronised and sampled, 3 us delay both edges
// - warning, shutdown, limit, power good need 20 us; overload 1 ms
// - reset pin low holds off with bias and reference down
// - before standby: bias up rail off, then load defaults rail off
// - standby: rail off, registers open, enable request accepted
// - regulating while conditions hold and rail enabled, registers open
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "fpms_defs.svh"
module fpms_top #(
   parameter int unsigned LONG_CYC = `FPMS_LONG_CYC
) (
   input  wire logic        CORE_CLK,
   input  wire logic        RESET,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        ANALOG_SUPPLY_OK,
   input  wire logic        EXT_RESET_N,
   input  wire logic        ENABLE_PIN_A,
   input  wire logic        ENABLE_PIN_B,
   input  wire logic        THERMAL_WARNING,
   input  wire logic        THERMAL_SHUTDOWN,
   input  wire logic        CURRENT_LIMIT_SIGNAL,
   input  wire logic        POWER_GOOD,
   input  wire logic        FEEDBACK_RAIL0_LOW,
   output logic             RAIL_ENABLE,
   output logic             DISCHARGE_EN,
   output logic             BIAS_EN,
   output logic             OTP_LOAD,
   output logic             IRQ_OUT_N
);
   ////////////////////////////////////////////////////////////////////
   fpms_pkg::fpms_state_t   state;
   fpms_pkg::fpms_state_t   next_state;
   fpms_pkg::fpms_ctrl_t    ctrl;
   fpms_pkg::fpms_flags_t   flags;
   fpms_pkg::fpms_flags_t   mask;
   fpms_pkg::fpms_flags_t   clr;
   logic [`FPMS_N_IN-1:0]   sync1;
   logic [`FPMS_N_IN-1:0]   syncd;
   logic [3:0]              filt;
   logic                    en_a;
   logic                    en_b;
   logic [9:0]              en_cnt;
   logic                    fb_filt;
   logic [31:0]             fb_cnt;
   logic [31:0]             start_cnt;
   logic                    start_done;
   logic                    trip;
   logic                    sd_block;
   logic                    rail_req;
   logic                    wr;
   logic                    rd_setup;
   logic                    irq_any;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `FPMS_OFS_CTRL) || (a == `FPMS_OFS_FLAGS) ||
               (a == `FPMS_OFS_MASK) || (a == `FPMS_OFS_STATUS);
   endfunction : mapped

   ////////////////////////////////////////////////////////////////////
   // two flops per pin; only the second is read
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         sync1 <= '0;
         syncd <= '0;
      end else begin
         sync1 <= {FEEDBACK_RAIL0_LOW, POWER_GOOD, CURRENT_LIMIT_SIGNAL, THERMAL_SHUTDOWN,
                   THERMAL_WARNING, ENABLE_PIN_B, ENABLE_PIN_A, EXT_RESET_N, ANALOG_SUPPLY_OK};
         syncd <= sync1;
      end
   end

   // enable pins sampled on a fixed tick: delay without glitch rejection
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         en_cnt <= '0;
         en_a   <= 1'b0;
         en_b   <= 1'b0;
      end else if (en_cnt == 10'(`FPMS_EN_CYC - 1)) begin
         en_cnt <= '0;
         en_a   <= syncd[`FPMS_I_ENA];
         en_b   <= syncd[`FPMS_I_ENB];
      end else begin
         en_cnt <= en_cnt + 10'h001;
      end
   end

   // symmetric debounce: output follows once the input held for the window
   for (genvar g = 0; g < 4; g++) begin : g_db
      logic [11:0] cnt;
      always_ff @(posedge CORE_CLK or posedge RESET) begin
         if (RESET) begin
            cnt     <= '0;
            filt[g] <= 1'b0;
         end else if (syncd[`FPMS_I_WARN + g] == filt[g]) begin
            cnt <= '0;
         end else if (cnt == 12'(`FPMS_DB_CYC - 1)) begin
            cnt     <= '0;
            filt[g] <= syncd[`FPMS_I_WARN + g];
         end else begin
            cnt <= cnt + 12'h001;
         end
      end
   end

   // long window kept as a parameter so a bench can shorten it
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         fb_cnt  <= '0;
         fb_filt <= 1'b0;
      end else if (!start_done) begin
         // armed only after the start window, else a rail off in standby reads as overload
         fb_cnt  <= '0;
         fb_filt <= 1'b0;
      end else if (syncd[`FPMS_I_FB] == fb_filt) begin
         fb_cnt <= '0;
      end else if (fb_cnt == LONG_CYC - 1) begin
         fb_cnt  <= '0;
         fb_filt <= syncd[`FPMS_I_FB];
      end else begin
         fb_cnt <= fb_cnt + 32'h0000_0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // start window measured from rail enable
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         start_cnt  <= '0;
         start_done <= 1'b0;
      end else if (state != fpms_pkg::ST_REG) begin
         start_cnt  <= '0;
         start_done <= 1'b0;
      end else if (!start_done) begin
         start_cnt  <= start_cnt + 32'h0000_0001;
         start_done <= (start_cnt == LONG_CYC - 1);
      end
   end

   always_comb begin
      trip = 1'b0;
      if (state == fpms_pkg::ST_REG) begin
         if (!start_done && start_cnt == LONG_CYC - 1 && syncd[`FPMS_I_FB]) begin
            trip = 1'b1;
         end else if (start_done && fb_filt) begin
            trip = 1'b1;
         end
      end
   end

   assign sd_block = filt[`FPMS_I_SD - `FPMS_I_WARN] | flags.sd;
   assign rail_req = ctrl.rail_en | (ctrl.pin_ctrl & (ctrl.pin_sel ? en_b : en_a));

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      unique case (state)
         fpms_pkg::ST_OFF:  next_state = fpms_pkg::ST_BIAS;
         fpms_pkg::ST_BIAS: next_state = fpms_pkg::ST_FUSE;
         fpms_pkg::ST_FUSE: next_state = fpms_pkg::ST_STBY;
         fpms_pkg::ST_STBY: begin
            if (rail_req && !flags.sc && !sd_block) begin
               next_state = fpms_pkg::ST_REG;
            end
         end
         fpms_pkg::ST_REG: begin
            if (trip || sd_block || !rail_req) begin
               next_state = fpms_pkg::ST_STBY;
            end
         end
         default: next_state = fpms_pkg::ST_OFF;
      endcase
      // lockout and reset pin bypass every filter
      if (!syncd[`FPMS_I_SUPPLY] || !syncd[`FPMS_I_EXT_RESET_N]) begin
         next_state = fpms_pkg::ST_OFF;
      end
   end

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         state        <= fpms_pkg::ST_OFF;
         RAIL_ENABLE  <= 1'b0;
         DISCHARGE_EN <= 1'b1;
         BIAS_EN      <= 1'b0;
         OTP_LOAD     <= 1'b0;
      end else begin
         state        <= next_state;
         RAIL_ENABLE  <= (next_state == fpms_pkg::ST_REG);
         DISCHARGE_EN <= (next_state == fpms_pkg::ST_OFF) | ((next_state != fpms_pkg::ST_REG) & ctrl.disch_en);
         BIAS_EN      <= (next_state != fpms_pkg::ST_OFF);
         OTP_LOAD     <= (next_state == fpms_pkg::ST_FUSE);
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign wr       = PSEL & PENABLE & PWRITE & mapped(PADDR);
   assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
   assign PREADY   = 1'b1;
   assign PSLVERR  = PSEL & PENABLE & ~mapped(PADDR);
   assign clr      = (wr && PADDR == `FPMS_OFS_FLAGS) ? fpms_pkg::fpms_flags_t'(PWDATA[5:0]) : '0;

   // defaults reloaded while loading fuses
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         ctrl <= fpms_pkg::fpms_ctrl_t'(`FPMS_CTRL_RST);
         mask <= fpms_pkg::fpms_flags_t'(`FPMS_MASK_RST);
      end else if (state == fpms_pkg::ST_FUSE) begin
         ctrl <= fpms_pkg::fpms_ctrl_t'(`FPMS_CTRL_RST);
         mask <= fpms_pkg::fpms_flags_t'(`FPMS_MASK_RST);
      end else if (wr && PADDR == `FPMS_OFS_CTRL) begin
         ctrl <= fpms_pkg::fpms_ctrl_t'(PWDATA[3:0]);
      end else if (wr && PADDR == `FPMS_OFS_MASK) begin
         mask <= fpms_pkg::fpms_flags_t'(PWDATA[5:0]);
      end
   end

   // set beats clear; live conditions keep their flag
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         flags <= fpms_pkg::fpms_flags_t'(`FPMS_FLAGS_RST);
      end else if (state == fpms_pkg::ST_FUSE) begin
         flags     <= fpms_pkg::fpms_flags_t'(`FPMS_FLAGS_RST);
         flags.rst <= 1'b1;
      end else if (state != fpms_pkg::ST_OFF) begin
         flags.sc   <= trip | (flags.sc & ~clr.sc);
         flags.sd   <= filt[`FPMS_I_SD - `FPMS_I_WARN] | (flags.sd & ~clr.sd);
         flags.warn <= filt[`FPMS_I_WARN - `FPMS_I_WARN] | (flags.warn & ~clr.warn);
         flags.ilim <= filt[`FPMS_I_ILIM - `FPMS_I_WARN] | (flags.ilim & ~clr.ilim);
         flags.pg   <= filt[`FPMS_I_PG - `FPMS_I_WARN] | (flags.pg & ~clr.pg);
         flags.rst  <= flags.rst & ~clr.rst;
      end
   end

   // short and thermal shutdown cannot be masked
   assign irq_any = flags.sc | flags.sd | |(flags & ~mask & 6'h3C);

   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         IRQ_OUT_N <= 1'b1;
      end else begin
         IRQ_OUT_N <= ~irq_any;
      end
   end

   // read data caught in the setup cycle, shown in the access cycle
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         PRDATA <= '0;
      end else if (rd_setup) begin
         PRDATA <= '0;
         unique case (PADDR)
            `FPMS_OFS_CTRL:  PRDATA[3:0] <= ctrl;
            `FPMS_OFS_MASK:  PRDATA[5:0] <= mask;
            `FPMS_OFS_FLAGS: begin
               PRDATA[5:0]             <= flags;
               PRDATA[`FPMS_B_SUMMARY] <= flags.sc | flags.ilim | flags.pg;
            end
            `FPMS_OFS_STATUS: begin
               PRDATA[`FPMS_B_RAILON]                   <= (state == fpms_pkg::ST_REG);
               PRDATA[`FPMS_B_SD]                       <= filt[`FPMS_I_SD - `FPMS_I_WARN];
               PRDATA[`FPMS_B_WARN]                     <= filt[`FPMS_I_WARN - `FPMS_I_WARN];
               PRDATA[`FPMS_B_ILIM]                     <= filt[`FPMS_I_ILIM - `FPMS_I_WARN];
               PRDATA[`FPMS_B_PG]                       <= filt[`FPMS_I_PG - `FPMS_I_WARN];
               PRDATA[`FPMS_B_STATE_HI:`FPMS_B_STATE_LO] <= state;
            end
            default: PRDATA <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   a_trip_sets_flag: assert property (@(posedge CORE_CLK) disable iff (RESET)
      trip && syncd[`FPMS_I_SUPPLY] && syncd[`FPMS_I_EXT_RESET_N] |=> flags.sc ##1 !IRQ_OUT_N)
      else $error("trip did not set short flag and irq");
   a_trip_rail_off: assert property (@(posedge CORE_CLK) disable iff (RESET)
      trip |=> !RAIL_ENABLE && state != fpms_pkg::ST_REG)
      else $error("rail stayed on after trip");
   a_sc_sticky: assert property (@(posedge CORE_CLK) disable iff (RESET)
      flags.sc && !clr.sc && state != fpms_pkg::ST_FUSE |=> flags.sc)
      else $error("short flag cleared without write");
   a_sd_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
      filt[`FPMS_I_SD - `FPMS_I_WARN] && state != fpms_pkg::ST_OFF && state != fpms_pkg::ST_FUSE |=> flags.sd)
      else $error("thermal flag clear while condition present");
   a_sd_block: assert property (@(posedge CORE_CLK) disable iff (RESET)
      state != fpms_pkg::ST_REG && sd_block |=> state != fpms_pkg::ST_REG)
      else $error("rail enabled under thermal block");
   a_uvlo_off: assert property (@(posedge CORE_CLK) disable iff (RESET)
      !syncd[`FPMS_I_SUPPLY] |=> state == fpms_pkg::ST_OFF && !RAIL_ENABLE && DISCHARGE_EN)
      else $error("lockout did not force off");
   a_up_sequence: assert property (@(posedge CORE_CLK) disable iff (RESET)
      state == fpms_pkg::ST_OFF && syncd[`FPMS_I_SUPPLY] && syncd[`FPMS_I_EXT_RESET_N] &&
      $past(syncd[`FPMS_I_SUPPLY]) |=> (state == fpms_pkg::ST_BIAS) or !syncd[`FPMS_I_EXT_RESET_N] or !syncd[`FPMS_I_SUPPLY])
      else $error("no bias step after off");
   a_reset_flag: assert property (@(posedge CORE_CLK) disable iff (RESET)
      state == fpms_pkg::ST_FUSE |=> flags.rst && ctrl == fpms_pkg::fpms_ctrl_t'(`FPMS_CTRL_RST))
      else $error("reset flag not raised after off");
   a_off_hold: assert property (@(posedge CORE_CLK) disable iff (RESET)
      !syncd[`FPMS_I_EXT_RESET_N] |=> state == fpms_pkg::ST_OFF ##0 !BIAS_EN)
      else $error("reset pin low did not hold off");
   a_irq_release: assert property (@(posedge CORE_CLK) disable iff (RESET)
      !irq_any |=> IRQ_OUT_N)
      else $error("irq held with no unmasked flag");
   a_irq_raise: assert property (@(posedge CORE_CLK) disable iff (RESET)
      irq_any |=> !IRQ_OUT_N)
      else $error("irq not pulled low with unmasked flag");
   a_overload_trip: assert property (@(posedge CORE_CLK) disable iff (RESET)
      state == fpms_pkg::ST_REG && start_done && fb_filt |=> !RAIL_ENABLE)
      else $error("rail stayed on under overload");
   a_retry_start: assert property (@(posedge CORE_CLK) disable iff (RESET)
      state == fpms_pkg::ST_STBY && rail_req && !flags.sc && !sd_block && syncd[`FPMS_I_SUPPLY] &&
      syncd[`FPMS_I_EXT_RESET_N] |=> state == fpms_pkg::ST_REG)
      else $error("no start while enable requested");
   a_sd_standby: assert property (@(posedge CORE_CLK) disable iff (RESET)
      state == fpms_pkg::ST_REG && filt[`FPMS_I_SD - `FPMS_I_WARN] && syncd[`FPMS_I_SUPPLY] &&
      syncd[`FPMS_I_EXT_RESET_N] |=> state == fpms_pkg::ST_STBY && !RAIL_ENABLE)
      else $error("thermal shutdown did not go standby");
   a_rail_only_reg: assert property (@(posedge CORE_CLK) disable iff (RESET)
      state != fpms_pkg::ST_REG |-> !RAIL_ENABLE)
      else $error("rail on outside regulation");
   a_fuse_bias: assert property (@(posedge CORE_CLK) disable iff (RESET)
      OTP_LOAD |-> BIAS_EN && !RAIL_ENABLE)
      else $error("defaults load without bias or with rail on");
endmodule : fpms_top

//--- inc/fpms_defs.svh
// constants of the fault protection and mode sequencer
// assumes inclusion by bare name from the package and the top module
`ifndef FPMS_DEFS_SVH
`define FPMS_DEFS_SVH
// apb register byte offsets
`define FPMS_OFS_CTRL    8'h00
`define FPMS_OFS_FLAGS   8'h04
`define FPMS_OFS_MASK    8'h08
`define FPMS_OFS_STATUS  8'h0C
// flag, mask and status bit positions
`define FPMS_B_SC        0
`define FPMS_B_SD        1
`define FPMS_B_WARN      2
`define FPMS_B_ILIM      3
`define FPMS_B_RST       4
`define FPMS_B_PG        5
`define FPMS_B_SUMMARY   7
`define FPMS_B_RAILON    0
`define FPMS_B_STATE_LO  5
`define FPMS_B_STATE_HI  9
// control bit positions
`define FPMS_B_RAIL_EN   0
`define FPMS_B_PIN_CTRL  1
`define FPMS_B_PIN_SEL   2
`define FPMS_B_DISCH     3
// reset values
`define FPMS_CTRL_RST    4'h8
`define FPMS_MASK_RST    6'h00
`define FPMS_FLAGS_RST   6'h00
// synchroniser lanes
`define FPMS_N_IN        9
`define FPMS_I_SUPPLY    0
`define FPMS_I_EXT_RESET_N      1
`define FPMS_I_ENA       2
`define FPMS_I_ENB       3
`define FPMS_I_WARN      4
`define FPMS_I_SD        5
`define FPMS_I_ILIM      6
`define FPMS_I_PG        7
`define FPMS_I_FB        8
// timing
`define FPMS_CLK_NS      5
`define FPMS_EN_NS       3000
`define FPMS_DB_NS       20000
`define FPMS_LONG_NS     1000000
`define FPMS_EN_CYC      ((`FPMS_EN_NS + `FPMS_CLK_NS - 1) / `FPMS_CLK_NS)
`define FPMS_DB_CYC      ((`FPMS_DB_NS + `FPMS_CLK_NS - 1) / `FPMS_CLK_NS)
`define FPMS_LONG_CYC    ((`FPMS_LONG_NS + `FPMS_CLK_NS - 1) / `FPMS_CLK_NS)
`endif

//--- inc/fpms_pkg.sv
// types of the fault protection and mode sequencer
// assumes fpms_defs.svh on the include path
`include "fpms_defs.svh"
package fpms_pkg;
   typedef enum logic [4:0] {
      ST_OFF  = 5'h01,
      ST_BIAS = 5'h02,
      ST_FUSE = 5'h04,
      ST_STBY = 5'h08,
      ST_REG  = 5'h10
   } fpms_state_t;

   typedef struct packed {
      logic disch_en;
      logic pin_sel;
      logic pin_ctrl;
      logic rail_en;
   } fpms_ctrl_t;

   typedef struct packed {
      logic pg;
      logic rst;
      logic ilim;
      logic warn;
      logic sd;
      logic sc;
   } fpms_flags_t;
endpackage : fpms_pkg

//--- verification/fpms_rail_plant.sv
// behavioural model of the rail around the sequencer: output ramp and feedback comparator
// assumes the bench picks healthy or shorted output through short_mode
`timescale 1ns/100ps
module fpms_rail_plant (
   input  wire logic CORE_CLK,
   input  wire logic RAIL_ENABLE,
   input  wire logic short_mode,
   output logic      FEEDBACK_RAIL0_LOW
);
   logic [3:0] ramp = 4'h0;
   initial FEEDBACK_RAIL0_LOW = 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   // output needs a few cycles to climb, so feedback reads low just after turn-on
   always @(posedge CORE_CLK) begin
      if (RAIL_ENABLE !== 1'b1) ramp <= 4'h0;
      else if (ramp != 4'hF) ramp <= ramp + 4'h1;
   end
   // a shorted output never climbs above the fault level
   always @(posedge CORE_CLK) begin
      FEEDBACK_RAIL0_LOW <= (RAIL_ENABLE !== 1'b1) || short_mode || (ramp < 4'h8);
   end
endmodule : fpms_rail_plant

//--- verification/tb_fpms_top.sv
// self-checking bench of the fault protection and mode sequencer
// assumes fpms_defs.svh on the include path; short overload window of 50 cycles
`timescale 1ns/100ps
`include "fpms_defs.svh"
module tb_fpms_top;
   localparam int LONG = 50;
   localparam int DB   = `FPMS_DB_CYC;
   localparam int EN   = `FPMS_EN_CYC;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} fpms_row_t;
   logic        CORE_CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, short_mode, otp_seen, otp_bad;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA, r;
   logic        ANALOG_SUPPLY_OK, EXT_RESET_N, ENABLE_PIN_A, ENABLE_PIN_B, THERMAL_WARNING;
   logic        THERMAL_SHUTDOWN, CURRENT_LIMIT_SIGNAL, POWER_GOOD, FEEDBACK_RAIL0_LOW;
   logic        RAIL_ENABLE, DISCHARGE_EN, BIAS_EN, OTP_LOAD, IRQ_OUT_N;
   int          n_mismatch, cmp_count, n;
   fpms_row_t   rows [8];
   ////////////////////////////////////////////////////////////////////////////////
   fpms_top #(.LONG_CYC(LONG)) u_dut (.CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .ANALOG_SUPPLY_OK(ANALOG_SUPPLY_OK), .EXT_RESET_N(EXT_RESET_N), .ENABLE_PIN_A(ENABLE_PIN_A),
      .ENABLE_PIN_B(ENABLE_PIN_B), .THERMAL_WARNING(THERMAL_WARNING), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN),
      .CURRENT_LIMIT_SIGNAL(CURRENT_LIMIT_SIGNAL), .POWER_GOOD(POWER_GOOD),
      .FEEDBACK_RAIL0_LOW(FEEDBACK_RAIL0_LOW), .RAIL_ENABLE(RAIL_ENABLE), .DISCHARGE_EN(DISCHARGE_EN),
      .BIAS_EN(BIAS_EN), .OTP_LOAD(OTP_LOAD), .IRQ_OUT_N(IRQ_OUT_N));
   fpms_rail_plant u_plant (.CORE_CLK(CORE_CLK), .RAIL_ENABLE(RAIL_ENABLE), .short_mode(short_mode),
      .FEEDBACK_RAIL0_LOW(FEEDBACK_RAIL0_LOW));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      CORE_CLK = 1'b0;
      forever #2.5 CORE_CLK = ~CORE_CLK;
   end
   // defaults load must happen with bias up and the rail off
   always @(posedge CORE_CLK) begin
      if (OTP_LOAD === 1'b1) otp_seen <= 1'b1;
      if (OTP_LOAD === 1'b1 && (RAIL_ENABLE !== 1'b0 || BIAS_EN !== 1'b1)) otp_bad <= 1'b1;
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // request held until pready is sampled high, released only after that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
      @(posedge CORE_CLK);
      PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do @(posedge CORE_CLK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0; PENABLE <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      logic e;
      apb(1'b0, a, 32'h0, q, e);
   endtask : rd
   // bounded wait, sampled once the edge's updates have landed
   task automatic wait_on(ref logic s, input logic v, input int lim, output int k);
      k = 0;
      while (s !== v && k < lim) begin
         @(posedge CORE_CLK);
         #1;
         k++;
      end
   endtask : wait_on
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (60000) @(posedge CORE_CLK);
      n_mismatch++;
      close_out();
   end
   initial begin
      logic e;
      RESET = 1'b1; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 8'h00; PWDATA = 32'h0;
      ANALOG_SUPPLY_OK = 1'b1; EXT_RESET_N = 1'b1; ENABLE_PIN_A = 1'b0; ENABLE_PIN_B = 1'b0;
      THERMAL_WARNING = 1'b0; THERMAL_SHUTDOWN = 1'b0; CURRENT_LIMIT_SIGNAL = 1'b0; POWER_GOOD = 1'b0;
      short_mode = 1'b0; otp_seen = 1'b0; otp_bad = 1'b0; n_mismatch = 0; cmp_count = 0;
      rows = '{'{0, 8'h00, 0, 32'h8, 0}, '{0, 8'h08, 0, 32'h0, 0}, '{1, 8'h08, 32'h3C, 0, 0},
               '{0, 8'h08, 0, 32'h3C, 0}, '{1, 8'h08, 32'h0, 0, 0}, '{1, 8'h0C, 32'hFFFFFFFF, 0, 0},
               '{0, 8'h0C, 0, 32'h100, 0}, '{0, 8'h10, 0, 32'h0, 1}};
      repeat (2) @(posedge CORE_CLK);
      #1;
      chk("outs in reset", 32'({RAIL_ENABLE, DISCHARGE_EN, BIAS_EN, IRQ_OUT_N}), 32'h5);
      @(posedge CORE_CLK) RESET <= 1'b0;
      wait_on(IRQ_OUT_N, 1'b0, 100, n);
      chk("irq after power-up", 32'(IRQ_OUT_N), 32'h0);
      rd(`FPMS_OFS_FLAGS, r);
      chk("flags after power-up", r, 32'h10);
      rd(`FPMS_OFS_STATUS, r);
      chk("standby after power-up", r, 32'h100);
      chk("defaults load seen", 32'({otp_seen, otp_bad}), 32'h2);
      wr(`FPMS_OFS_FLAGS, 32'h10);
      wait_on(IRQ_OUT_N, 1'b1, 4, n);
      chk("irq after reset flag clear", 32'(IRQ_OUT_N), 32'h1);
      $display("test power-up done");
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d, r, e);
         if (!rows[i].w) chk("table read", r, rows[i].exp);
         chk("table error", 32'(e), 32'(rows[i].err));
      end
      $display("test register table done");
      wr(`FPMS_OFS_CTRL, 32'h9);
      wait_on(RAIL_ENABLE, 1'b1, 10, n);
      repeat (LONG + 20) @(posedge CORE_CLK);
      #1;
      chk("rail held with good output", 32'({RAIL_ENABLE, DISCHARGE_EN}), 32'h2);
      rd(`FPMS_OFS_STATUS, r);
      chk("regulating status", r, 32'h201);
      $display("test regulate done");
      short_mode <= 1'b1;
      wait_on(RAIL_ENABLE, 1'b0, LONG + 20, n);
      chk("overload trip time", 32'(n >= LONG - 2 && n <= LONG + 10), 32'h1);
      wait_on(IRQ_OUT_N, 1'b0, 4, n);
      chk("irq on trip", 32'(IRQ_OUT_N), 32'h0);
      rd(`FPMS_OFS_FLAGS, r);
      chk("trip flags", r, 32'h81);
      rd(`FPMS_OFS_STATUS, r);
      chk("trip status", r, 32'h100);
      wr(`FPMS_OFS_FLAGS, 32'h7E);
      rd(`FPMS_OFS_FLAGS, r);
      chk("short flag kept", r, 32'h81);
      wr(`FPMS_OFS_FLAGS, 32'h1);
      wait_on(RAIL_ENABLE, 1'b1, 6, n);
      chk("retry after clear", 32'(RAIL_ENABLE), 32'h1);
      wait_on(RAIL_ENABLE, 1'b0, LONG + 20, n);
      chk("start-up short time", 32'(n >= LONG - 2 && n <= LONG + 6), 32'h1);
      short_mode <= 1'b0;
      wr(`FPMS_OFS_FLAGS, 32'h1);
      wait_on(RAIL_ENABLE, 1'b1, 6, n);
      repeat (LONG + 20) @(posedge CORE_CLK);
      #1;
      chk("healthy retry holds", 32'({RAIL_ENABLE, IRQ_OUT_N}), 32'h3);
      $display("test short-circuit done");
      @(posedge CORE_CLK) THERMAL_SHUTDOWN <= 1'b1;
      wait_on(RAIL_ENABLE, 1'b0, DB + 20, n);
      chk("thermal filter time", 32'(n >= DB - 2 && n <= DB + 10), 32'h1);
      wait_on(IRQ_OUT_N, 1'b0, 4, n);
      rd(`FPMS_OFS_STATUS, r);
      chk("thermal status", r, 32'h102);
      wr(`FPMS_OFS_FLAGS, 32'h2);
      rd(`FPMS_OFS_FLAGS, r);
      chk("thermal flag kept while hot", r, 32'h2);
      THERMAL_SHUTDOWN <= 1'b0;
      repeat (DB + 20) @(posedge CORE_CLK);
      rd(`FPMS_OFS_STATUS, r);
      chk("cool but flag pending", 32'({r[9:0], RAIL_ENABLE, IRQ_OUT_N}), 32'h400);
      wr(`FPMS_OFS_FLAGS, 32'h2);
      wait_on(RAIL_ENABLE, 1'b1, 10, n);
      chk("rail back after clear", 32'({RAIL_ENABLE, IRQ_OUT_N}), 32'h3);
      $display("test thermal done");
      wr(`FPMS_OFS_CTRL, 32'hA);
      wait_on(RAIL_ENABLE, 1'b0, 10, n);
      @(posedge CORE_CLK) ENABLE_PIN_A <= 1'b1;
      wait_on(RAIL_ENABLE, 1'b1, EN + 20, n);
      chk("pin rise delay", 32'(n <= EN + 10 && RAIL_ENABLE === 1'b1), 32'h1);
      @(posedge CORE_CLK) ENABLE_PIN_A <= 1'b0;
      wait_on(RAIL_ENABLE, 1'b0, EN + 20, n);
      chk("pin fall delay", 32'(n <= EN + 10 && RAIL_ENABLE === 1'b0), 32'h1);
      $display("test enable pin done");
      wr(`FPMS_OFS_CTRL, 32'h1);
      wait_on(RAIL_ENABLE, 1'b1, 10, n);
      @(posedge CORE_CLK) ANALOG_SUPPLY_OK <= 1'b0;
      wait_on(RAIL_ENABLE, 1'b0, 6, n);
      chk("lockout without filter", 32'(n <= 4), 32'h1);
      repeat (2) @(posedge CORE_CLK);
      #1;
      chk("lockout outputs", 32'({RAIL_ENABLE, DISCHARGE_EN, BIAS_EN}), 32'h2);
      @(posedge CORE_CLK) ANALOG_SUPPLY_OK <= 1'b1;
      wait_on(IRQ_OUT_N, 1'b0, 100, n);
      rd(`FPMS_OFS_CTRL, r);
      chk("defaults after lockout", 32'({r[3:0], IRQ_OUT_N}), 32'h10);
      $display("test lockout done");
      @(posedge CORE_CLK) EXT_RESET_N <= 1'b0;
      repeat (6) @(posedge CORE_CLK);
      #1;
      chk("reset pin holds off", 32'({BIAS_EN, RAIL_ENABLE, DISCHARGE_EN}), 32'h1);
      @(posedge CORE_CLK) EXT_RESET_N <= 1'b1;
      wait_on(BIAS_EN, 1'b1, 20, n);
      chk("bias after reset pin", 32'(BIAS_EN), 32'h1);
      $display("test reset pin done");
      close_out();
   end
endmodule : tb_fpms_top
